// ==== rtl/sem_regs.svh ====
// Constants of the serial memory master: fields, codes, reset values and timing
// Function
// - Two-pin mode uses pins four and five
// - Data then code 0011 starts byte transmit
// - Busy falls at end; completion pulse then
// - Status bit 5 low means ACK received
// - Status bit 4 low means ACK sent
// - Code 0001 receives byte, sends ACK
// - Code 0110 receives last byte, no ACK
// - Code 0101 gives STOP, 1001 START
// - Code 0000 stops the free running clock
// - Unknown code does nothing, sets error bit 7
// - Two-pin clock 78kHz, runs between transfers from START until code 0000
// - Pin select 3 gives 500kHz three-pin mode
// - Control write starts at most 8 bits
// - Issue exactly count clocks, 0 to 8
// - Read bits MSB first, right justified
// - Write bits MSB first from data MSB
// - Zero count: no clocks, data obeys float
// - Float releases data after last rising edge
// - Wait-ready with float delays busy until data rises
// - Bit 6 busy; completion pulse on fall
`ifndef SEM_REGS_SVH
`define SEM_REGS_SVH
// ****************************************
// Control register fields
// ****************************************
`define SEM_BIT_ERROR 7
`define SEM_BIT_BUSY 6
`define SEM_BIT_RXACK 5
`define SEM_BIT_TXACK 4
`define SEM_BIT_WFR 7
`define SEM_BIT_FLOAT 5
`define SEM_BIT_RD 4
`define SEM_CNT_MAX 4'h8
// ****************************************
// Pin select values and command codes
// ****************************************
`define SEM_SEL_2W 2'h1
`define SEM_SEL_3W 2'h3
`define SEM_CMD_NOP 4'h0
`define SEM_CMD_RX 4'h1
`define SEM_CMD_TX 4'h3
`define SEM_CMD_STOP 4'h5
`define SEM_CMD_RXLAST 4'h6
`define SEM_CMD_START 4'h9
// ****************************************
// Reset values
// ****************************************
`define SEM_RST_ACKN 1'h1
`define SEM_RST_DATA 8'h00
// ****************************************
// Timing: half bit periods in clk_sys cycles
// ****************************************
`define SEM_CLK_HZ 50000000
`define SEM_FREQ_2W_HZ 78000
`define SEM_FREQ_3W_HZ 500000
`define SEM_HALF_2W ((`SEM_CLK_HZ + 2 * `SEM_FREQ_2W_HZ - 1) / (2 * `SEM_FREQ_2W_HZ))
`define SEM_HALF_3W ((`SEM_CLK_HZ + 2 * `SEM_FREQ_3W_HZ - 1) / (2 * `SEM_FREQ_3W_HZ))
`define SEM_DIV_W 9
`endif

// ==== rtl/sem_pkg.sv ====
// Types of the serial memory master
package sem_pkg;
  // Engine states, Gray coded
  typedef enum logic [1:0] {
    SEM_IDLE = 2'b00,
    SEM_RUN = 2'b01,
    SEM_WAIT = 2'b11
  } sem_state_t;
  // Decoded operations
  typedef enum logic [2:0] {
    OP_NOP, OP_START, OP_STOP, OP_TX, OP_RX, OP_RXLAST, OP_3W, OP_BAD
  } sem_op_t;
  // Three-pin control word
  typedef struct packed {
    logic wait_ready_flag;
    logic unused6;
    logic float_after_last_edge;
    logic rd;
    logic [3:0] cnt;
  } sem_ctrl3_t;
  // Drive of the two pins
  typedef struct packed {
    logic sck;
    logic sdaOut;
    logic sdaOe;
  } sem_pins_t;
endpackage : sem_pkg

// ==== rtl/sem_serial_mem_master.sv ====
// Serial memory master engine with two-pin and three-pin modes
`timescale 1ns/1ns
`include "sem_regs.svh"
module sem_serial_mem_master import sem_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [1:0] memIfPinSelect,
  input wire logic serialMemControlWr,
  input wire logic serialMemDataWr,
  input wire logic [7:0] wrData,
  output logic [7:0] serialMemControlRd,
  output logic [7:0] serialMemDataRd,
  output logic busyOut,
  output logic completionIrqLine,
  output logic generalPinFourOut,
  output logic generalPinFourOe,
  input wire logic generalPinFiveIn,
  output logic generalPinFiveOut,
  output logic generalPinFiveOe
);
  // ****************************************
  // Helper functions
  // ****************************************
  // Command code to operation
  function automatic sem_op_t decodeCmd(input logic [3:0] c);
    case (c)
      `SEM_CMD_NOP: decodeCmd = OP_NOP;
      `SEM_CMD_RX: decodeCmd = OP_RX;
      `SEM_CMD_TX: decodeCmd = OP_TX;
      `SEM_CMD_STOP: decodeCmd = OP_STOP;
      `SEM_CMD_RXLAST: decodeCmd = OP_RXLAST;
      `SEM_CMD_START: decodeCmd = OP_START;
      default: decodeCmd = OP_BAD;
    endcase
  endfunction : decodeCmd
  function automatic logic [4:0] phaseCount(input sem_op_t op, input logic [3:0] cnt);
    case (op)
      OP_START, OP_STOP: phaseCount = 5'h03;
      OP_TX, OP_RX, OP_RXLAST: phaseCount = 5'h12;
      OP_3W: phaseCount = (cnt > `SEM_CNT_MAX) ? 5'h10 : {cnt, 1'b0};
      default: phaseCount = 5'h00;
    endcase
  endfunction : phaseCount
  // Pin drive for one phase
  function automatic sem_pins_t phasePins(input sem_op_t op, input logic [4:0] p,
      input logic [4:0] nPh, input logic [7:0] d, input sem_ctrl3_t c);
    logic [3:0] bitIx;
    logic hi;
    logic dBit;
    bitIx = p[4:1];
    hi = p[0];
    dBit = (bitIx < 4'h8) ? d[3'(4'h7 - bitIx)] : 1'b1;
    case (op)
      OP_START: phasePins = (p == 5'h00) ? 3'b011 : ((p == 5'h01) ? 3'b111 : 3'b101);
      OP_STOP: phasePins = (p == 5'h00) ? 3'b001 : ((p == 5'h01) ? 3'b101 : 3'b111);
      OP_TX: phasePins = (bitIx < 4'h8) ? {hi, dBit, 1'b1} : {hi, 1'b1, 1'b0};
      OP_RX: phasePins = (bitIx < 4'h8) ? {hi, 1'b1, 1'b0} : {hi, 1'b0, 1'b1};
      OP_RXLAST: phasePins = {hi, 1'b1, 1'b0};
      // Float from the last rising edge on
      OP_3W: phasePins = {hi, c.rd ? 1'b0 : dBit,
                          !c.rd && !(c.float_after_last_edge && p == nPh - 5'h01)};
      default: phasePins = 3'b111;
    endcase
  endfunction : phasePins
  // ****************************************
  // Declarations
  // ****************************************
  sem_state_t state_r; // Engine state
  sem_op_t op_r; // Operation in progress
  sem_ctrl3_t ctl_r; // Latched three-pin control
  sem_pins_t pins_r; // Registered pin drive
  logic [4:0] phase_r; // Next phase to enter
  logic [4:0] nPh_r; // Phases of this operation
  logic [`SEM_DIV_W-1:0] divCnt_r; // Bit clock divider
  logic [`SEM_DIV_W-1:0] halfLim; // Divider wrap value
  logic [7:0] data_r; // Data register
  logic [7:0] shift_r; // Receive shifter
  logic [7:0] shiftNxt; // Shifter with this tick's bit
  logic [7:0] ctrlRd_r; // Control readback
  logic [7:0] dataRd_r; // Data readback
  logic busy_r, irq_r, err_r; // Status
  logic rxAckN_r, txAckN_r; // Acknowledge flags
  logic clkRun_r; // Two-pin clock free running
  logic sckOe_r; // Clock pin enable
  logic sdaS1_r, sdaS2_r, sdaS3_r; // Data pin synchroniser
  logic mode2, mode3, tick, accept, stepRun, finRun, driveRun;
  logic sampleNow, sampleBit, waitReady, done, sdaRise;
  sem_op_t newOp;
  sem_pins_t drv;
  // ****************************************
  // Combinational control
  // ****************************************
  assign mode2 = (memIfPinSelect == `SEM_SEL_2W);
  assign mode3 = (memIfPinSelect == `SEM_SEL_3W);
  assign halfLim = mode3 ? `SEM_DIV_W'(`SEM_HALF_3W - 1) : `SEM_DIV_W'(`SEM_HALF_2W - 1);
  assign tick = (divCnt_r == halfLim);
  // Writes only taken when idle
  // busy blocks writes
  assign accept = serialMemControlWr && !busy_r && (mode2 || mode3);
  assign newOp = mode3 ? OP_3W : decodeCmd(wrData[3:0]);
  assign stepRun = (state_r == SEM_RUN) && tick;
  assign finRun = stepRun && (phase_r == nPh_r);
  assign driveRun = stepRun && !finRun;
  // Sample when leaving a high phase
  assign sampleNow = stepRun && (phase_r != 5'h00) && !phase_r[0];
  assign sampleBit = sampleNow && (phase_r <= 5'h10) &&
                     (op_r == OP_RX || op_r == OP_RXLAST || (op_r == OP_3W && ctl_r.rd));
  assign shiftNxt = sampleBit ? {shift_r[6:0], sdaS2_r} : shift_r;
  assign waitReady = (op_r == OP_3W) && ctl_r.float_after_last_edge && ctl_r.wait_ready_flag;
  assign sdaRise = sdaS2_r && !sdaS3_r;
  assign done = (finRun && !waitReady) || ((state_r == SEM_WAIT) && sdaRise);
  assign drv = phasePins(op_r, phase_r, nPh_r, data_r, ctl_r);
  // ****************************************
  // Bit clock divider
  // ****************************************
  // divider from clk_sys
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_r <= '0;
    end else if (tick || divCnt_r > halfLim) begin
      divCnt_r <= '0;
    end else begin
      divCnt_r <= divCnt_r + `SEM_DIV_W'(1);
    end
  end
  // ****************************************
  // Data pin synchroniser
  // ****************************************
  // Two stages plus a history stage
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sdaS1_r <= 1'b1;
      sdaS2_r <= 1'b1;
      sdaS3_r <= 1'b1;
    end else begin
      sdaS1_r <= generalPinFiveIn;
      sdaS2_r <= sdaS1_r;
      sdaS3_r <= sdaS2_r;
    end
  end
  // ****************************************
  // Engine sequencing
  // ****************************************
  // State, operation and phase counter
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= SEM_IDLE;
      op_r <= OP_NOP;
      ctl_r <= '0;
      phase_r <= 5'h00;
      nPh_r <= 5'h00;
      busy_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      irq_r <= 1'b0;
      case (state_r)
        SEM_IDLE: begin
          if (accept && newOp != OP_NOP && newOp != OP_BAD) begin
            state_r <= SEM_RUN;
            op_r <= newOp;
            ctl_r <= wrData;
            phase_r <= 5'h00;
            nPh_r <= phaseCount(newOp, wrData[3:0]);
            busy_r <= 1'b1;
          end
        end
        SEM_RUN: begin
          if (finRun) begin
            state_r <= waitReady ? SEM_WAIT : SEM_IDLE;
          end else if (driveRun) begin
            phase_r <= phase_r + 5'h01;
          end
        end
        SEM_WAIT: begin
          if (sdaRise) begin
            state_r <= SEM_IDLE;
          end
        end
        default: begin
          state_r <= SEM_IDLE;
        end
      endcase
      if (done) begin
        busy_r <= 1'b0;
        irq_r <= 1'b1;
      end
    end
  end
  // ****************************************
  // Status flags
  // ****************************************
  // Error, acknowledge and clock-run flags
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      err_r <= 1'b0;
      rxAckN_r <= `SEM_RST_ACKN;
      txAckN_r <= `SEM_RST_ACKN;
      clkRun_r <= 1'b0;
    end else begin
      if (accept && mode2) begin
        err_r <= (newOp == OP_BAD);
        if (newOp == OP_NOP) begin
          clkRun_r <= 1'b0;
        end else if (newOp == OP_START) begin
          clkRun_r <= 1'b1;
        end
        if (newOp == OP_RX || newOp == OP_RXLAST) begin
          txAckN_r <= 1'b1;
        end
      end
      if (sampleNow && op_r == OP_TX && phase_r == nPh_r) begin
        rxAckN_r <= sdaS2_r;
      end
      if (finRun && op_r == OP_RX) begin
        txAckN_r <= 1'b0;
      end
    end
  end
  // ****************************************
  // Data register and shifter
  // ****************************************
  // Software load, receive capture
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      data_r <= `SEM_RST_DATA;
      shift_r <= 8'h00;
    end else begin
      if (accept) begin
        shift_r <= 8'h00;
      end else begin
        shift_r <= shiftNxt;
      end
      if (serialMemDataWr && !busy_r) begin
        data_r <= wrData;
      end else if (finRun && sampleBit) begin
        data_r <= shiftNxt;
      end else if (finRun && (op_r == OP_RX || op_r == OP_RXLAST)) begin
        data_r <= shift_r;
      end
    end
  end
  // ****************************************
  // Pin drive
  // ****************************************
  // Clock and data pins, all registered
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pins_r <= 3'b110;
      sckOe_r <= 1'b0;
    end else begin
      // pins four and five carry bus
      sckOe_r <= mode2 || mode3;
      if (!(mode2 || mode3)) begin
        pins_r.sdaOe <= 1'b0;
      end else if (driveRun) begin
        pins_r <= drv;
      end else if (finRun && op_r == OP_3W) begin
        pins_r.sck <= 1'b0;
        if (nPh_r == 5'h00) begin
          pins_r.sdaOe <= !ctl_r.float_after_last_edge;
        end
      end else if (state_r == SEM_IDLE && !accept) begin
        if (mode2 && clkRun_r) begin
          pins_r.sck <= tick ? !pins_r.sck : pins_r.sck;
        end else begin
          pins_r.sck <= mode2;
        end
      end
    end
  end
  // ****************************************
  // Readback and outputs
  // ****************************************
  // Registered register views
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrlRd_r <= 8'h30;
      dataRd_r <= `SEM_RST_DATA;
    end else begin
      ctrlRd_r <= mode3 ? {1'b0, busy_r, 6'h00} : {err_r, busy_r, rxAckN_r, txAckN_r, 4'h0};
      dataRd_r <= data_r;
    end
  end
  assign serialMemControlRd = ctrlRd_r;
  assign serialMemDataRd = dataRd_r;
  assign busyOut = busy_r;
  assign completionIrqLine = irq_r;
  assign generalPinFourOut = pins_r.sck;
  assign generalPinFourOe = sckOe_r;
  assign generalPinFiveOut = pins_r.sdaOut;
  assign generalPinFiveOe = pins_r.sdaOe;
  // ****************************************
  // Assertions
  // ****************************************
  // Rising clock edges seen in a three-pin op
  logic [4:0] riseCnt_r;
  logic sckPrev_r;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      riseCnt_r <= 5'h00;
      sckPrev_r <= 1'b1;
    end else begin
      sckPrev_r <= pins_r.sck;
      if (accept) begin
        riseCnt_r <= 5'h00;
      end else if (pins_r.sck && !sckPrev_r && busy_r) begin
        riseCnt_r <= riseCnt_r + 5'h01;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_takeCmd(logic [3:0] c);
    accept && mode2 && wrData[3:0] == c;
  endsequence
  sequence s_busyEnds;
    $fell(busy_r);
  endsequence

  a_irq_on_fall: assert property (s_busyEnds |-> irq_r && !$past(irq_r))
    else $error("completion pulse missing at busy fall");
  a_tx_starts: assert property (s_takeCmd(`SEM_CMD_TX) |=> busy_r && op_r == OP_TX)
    else $error("transmit did not start");
  a_bad_cmd_err: assert property (accept && mode2 && newOp == OP_BAD |=> err_r && !busy_r)
    else $error("illegal command not flagged");
  a_noop_stop: assert property (s_takeCmd(`SEM_CMD_NOP) |=> !clkRun_r ##1 pins_r.sck)
    else $error("no-op left clock running");
  a_write_ignored: assert property (busy_r && serialMemControlWr |=> $stable(op_r))
    else $error("write taken while busy");
  a_clk_idle_high: assert property (state_r == SEM_IDLE && mode2 && !clkRun_r && !accept
      |=> pins_r.sck)
    else $error("two-pin clock not high while idle");
  a_float_last: assert property (driveRun && op_r == OP_3W && ctl_r.float_after_last_edge
      && phase_r == nPh_r - 5'h01 |=> !pins_r.sdaOe && pins_r.sck)
    else $error("data not floated after last rise");
  a_clock_count: assert property ((s_busyEnds and op_r == OP_3W)
      |-> riseCnt_r == nPh_r[4:1])
    else $error("three-pin clock count wrong");
  a_zero_count: assert property (finRun && op_r == OP_3W && nPh_r == 5'h00
      |=> pins_r.sdaOe == !ctl_r.float_after_last_edge && riseCnt_r == 5'h00)
    else $error("zero count misbehaved");
  a_wait_ready: assert property (state_r == SEM_WAIT && !sdaRise |=> busy_r)
    else $error("busy fell before data rose");
  a_rx_ack_sent: assert property (finRun && op_r == OP_RX |=> !txAckN_r ##1 !ctrlRd_r[4])
    else $error("sent acknowledge not flagged");
endmodule : sem_serial_mem_master

// ==== dv/sem_mem_model.sv ====
// Behavioural serial memory seen on the clock and data wires
`timescale 1ns/1ns
module sem_mem_model (
  input wire logic clk_sys,
  input wire logic sckWire,
  input wire logic sdaWire,
  input wire logic csRise,
  input wire logic readMode,
  input wire logic ackEn,
  input wire logic holdLow,
  input wire logic [7:0] txByte,
  output logic drvLow
);
  // ****************************************
  // Frame tracking
  // ****************************************
  logic sckQ; // Clock level one cycle ago
  logic sdaQ; // Data level one cycle ago
  int cnt = 0; // Clock falls since frame start
  int slot; // Bit slot now on the wire
  logic rdQ = 1'b0; // Direction taken at the last clock fall
  logic ackQ = 1'b0; // Acknowledge enable taken at the last clock fall
  assign slot = (cnt - 1) % 9;
  always @(posedge clk_sys) begin
    sckQ <= sckWire;
    sdaQ <= sdaWire;
    // Mode taken only while the clock is low, so a held slot never flips
    if (csRise) begin
      cnt <= 1;
      rdQ <= readMode;
      ackQ <= ackEn;
    end else if (sckQ && sckWire && sdaQ && !sdaWire) begin
      cnt <= 0;
    end else if (sckQ && !sckWire) begin
      cnt <= cnt + 1;
      rdQ <= readMode;
      ackQ <= ackEn;
    end
  end
  // ****************************************
  // Open-drain drive of the data wire
  // ****************************************
  // acknowledge and ready
  always_comb begin
    drvLow = holdLow;
    // Read bits, changed while the clock is low
    if (rdQ && slot >= 0 && slot < 8) begin
      drvLow = !txByte[7 - slot];
    end
    // Acknowledge slot of a written byte
    if (!rdQ && ackQ && slot == 8) begin
      drvLow = 1'b1;
    end
  end
endmodule : sem_mem_model

// ==== dv/sem_serial_mem_master_test.sv ====
// Self-checking bench of the serial memory master
`timescale 1ns/1ns
`include "sem_regs.svh"
module sem_serial_mem_master_test;
  // ****************************************
  // Signals
  // ****************************************
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] memIfPinSelect = 2'h0;
  logic serialMemControlWr = 1'b0;
  logic serialMemDataWr = 1'b0;
  logic [7:0] wrData = 8'h00;
  logic [7:0] serialMemControlRd, serialMemDataRd;
  logic busyOut, completionIrqLine, generalPinFourOut, generalPinFourOe;
  logic generalPinFiveOut, generalPinFiveOe, drvLow, sckWire, sdaWire;
  logic csRise = 1'b0, readMode = 1'b0, ackEn = 1'b0, holdLow = 1'b0;
  logic [7:0] txByte = 8'h00;
  logic [8:0] cap = 9'h000; // Bits seen at clock rises
  logic sckQ = 1'b1, sdaQ = 1'b1;
  logic [7:0] d, p;
  logic [7:0] bad [5] = '{8'h02, 8'h04, 8'h07, 8'h08, 8'h0F}; // Undefined codes
  int fails = 0, cmp_count = 0, rises = 0, starts = 0, stops = 0;
  int riseAt = 0, per = 0, cyc = 0, r, m;
  int seed = 30;
  // Clock of 20 ns
  always #10 clk_sys = ~clk_sys;
  // Wires with pull-ups
  assign sckWire = generalPinFourOe ? generalPinFourOut : 1'b1;
  assign sdaWire = !((generalPinFiveOe && !generalPinFiveOut) || drvLow);
  sem_serial_mem_master dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .memIfPinSelect(memIfPinSelect), .serialMemControlWr(serialMemControlWr),
    .serialMemDataWr(serialMemDataWr), .wrData(wrData),
    .serialMemControlRd(serialMemControlRd), .serialMemDataRd(serialMemDataRd),
    .busyOut(busyOut), .completionIrqLine(completionIrqLine),
    .generalPinFourOut(generalPinFourOut), .generalPinFourOe(generalPinFourOe),
    .generalPinFiveIn(sdaWire), .generalPinFiveOut(generalPinFiveOut),
    .generalPinFiveOe(generalPinFiveOe));
  sem_mem_model mem_u (.clk_sys(clk_sys), .sckWire(sckWire), .sdaWire(sdaWire),
    .csRise(csRise), .readMode(readMode), .ackEn(ackEn), .holdLow(holdLow),
    .txByte(txByte), .drvLow(drvLow));
  // ****************************************
  // Wire monitor: bits, period, start and stop
  // ****************************************
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    sckQ <= sckWire;
    sdaQ <= sdaWire;
    if (!sckQ && sckWire) begin
      cap <= {cap[7:0], sdaWire};
      rises <= rises + 1;
      per <= cyc - riseAt;
      riseAt <= cyc;
    end
    if (sckQ && sckWire && sdaQ && !sdaWire) starts <= starts + 1;
    if (sckQ && sckWire && !sdaQ && sdaWire) stops <= stops + 1;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task close_out;
    $display("fails=%0d comparisons=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  task chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One write strobe to control or data register
  task wr(input logic isCtl, input logic [7:0] v);
    @(posedge clk_sys);
    serialMemControlWr <= isCtl;
    serialMemDataWr <= !isCtl;
    wrData <= v;
    @(posedge clk_sys);
    serialMemControlWr <= 1'b0;
    serialMemDataWr <= 1'b0;
  endtask : wr
  // Let readback ports follow state
  task settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle
  // Busy must rise, then fall with the interrupt pulse
  task waitFall;
    int n;
    logic seen;
    seen = 1'b0;
    for (n = 0; n < 20000; n++) begin
      @(posedge clk_sys);
      #1;
      if (busyOut === 1'b1) seen = 1'b1;
      else if (seen) break;
    end
    if (n == 20000) begin
      fails++;
      close_out();
    end else begin
      chk(completionIrqLine, 1'b1);
    end
  endtask : waitFall
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    chk({serialMemControlRd, busyOut}, 9'h060);
    chk({serialMemDataRd, generalPinFiveOe}, 9'h000);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    memIfPinSelect <= `SEM_SEL_2W;
    settle;
    chk(generalPinFourOe, 1'b1);
    // Undefined codes: error, no busy
    foreach (bad[i]) begin
      wr(1'b1, bad[i]);
      settle;
      chk({serialMemControlRd[7], busyOut}, 9'h002);
    end
    wr(1'b1, {4'h0, `SEM_CMD_START});
    waitFall;
    settle;
    chk({serialMemControlRd[7], 8'(starts)}, 9'h001);
    // Bytes sent, memory acknowledging all but the second
    for (int i = 0; i < 3; i++) begin
      d = $random(seed);
      ackEn <= (i != 1);
      wr(1'b0, d);
      wr(1'b1, {4'h0, `SEM_CMD_TX});
      waitFall;
      settle;
      chk(cap, {d, i == 1});
      chk(serialMemControlRd[5], i == 1);
      chk(9'(per), 9'(2 * `SEM_HALF_2W));
    end
    p = $random(seed);
    txByte <= p;
    readMode <= 1'b1;
    wr(1'b1, {4'h0, `SEM_CMD_RX});
    waitFall;
    settle;
    chk({serialMemDataRd, cap[0]}, {p, 1'b0});
    chk(serialMemControlRd[4], 1'b0);
    p = $random(seed);
    txByte <= p;
    wr(1'b1, {4'h0, `SEM_CMD_RXLAST});
    waitFall;
    settle;
    chk({serialMemDataRd, cap[0]}, {p, 1'b1});
    readMode <= 1'b0;
    ackEn <= 1'b0;
    wr(1'b1, {4'h0, `SEM_CMD_STOP});
    waitFall;
    settle;
    chk(9'(stops), 9'h001);
    // Clock still free running: one rise within two half periods
    r = rises;
    repeat (700) @(posedge clk_sys);
    chk(9'(rises - r), 9'h001);
    wr(1'b1, {4'h0, `SEM_CMD_NOP});
    repeat (400) @(posedge clk_sys);
    r = rises;
    repeat (1000) @(posedge clk_sys);
    #1;
    chk({sckWire, 8'(rises - r)}, 9'h100);
    // Three-pin writes over every count
    memIfPinSelect <= `SEM_SEL_3W;
    for (int c = 0; c <= 8; c++) begin
      d = $random(seed);
      wr(1'b0, d);
      r = rises;
      wr(1'b1, 8'(c));
      if (c == 8) begin
        repeat (3) @(posedge clk_sys);
        #1;
        chk(serialMemControlRd[6], 1'b1);
        wr(1'b0, ~d);
        wr(1'b1, 8'h08);
      end
      waitFall;
      settle;
      m = (1 << c) - 1;
      chk(9'(rises - r), 9'(c));
      if (c > 1) chk(9'(per), 9'(2 * `SEM_HALF_3W));
      chk(9'(cap & m), 9'((d >> (8 - c)) & m));
      chk(generalPinFiveOe, 1'b1);
    end
    // Three-pin reads, each followed by a zero-count write
    for (int c = 1; c <= 8; c++) begin
      p = $random(seed);
      txByte <= p;
      readMode <= 1'b1;
      csRise <= 1'b1;
      @(posedge clk_sys);
      csRise <= 1'b0;
      wr(1'b1, 8'h10 | 8'(c));
      waitFall;
      readMode <= 1'b0;
      settle;
      m = (1 << c) - 1;
      chk(9'(serialMemDataRd & m), 9'((p >> (8 - c)) & m));
      wr(1'b1, 8'h00);
      waitFall;
      settle;
      chk(generalPinFiveOe, 1'b1);
    end
    // Float with wait-ready: memory holds data low
    holdLow <= 1'b1;
    wr(1'b0, 8'h00);
    // Wait-ready without float is ignored
    wr(1'b1, 8'h81);
    waitFall;
    wr(1'b1, 8'hA2);
    repeat (600) @(posedge clk_sys);
    #1;
    chk({busyOut, generalPinFiveOe}, 9'h002);
    holdLow <= 1'b0;
    waitFall;
    wr(1'b1, 8'h20);
    waitFall;
    settle;
    chk(generalPinFiveOe, 1'b0);
    close_out();
  end
endmodule : sem_serial_mem_master_test
